// ===== adc_spi_map.vh
// Constants for the converter serial result and configuration port.
// Assumes inclusion by the port design file only.
`ifndef ADC_SPI_MAP_VH
`define ADC_SPI_MAP_VH

`define RESULT_RESET 16'h0000
`define CONTROL_RESET 16'h058B
`define RESULT_MAX 16'h7FFF
`define RESULT_MIN 16'h8000

`define CW_START 15
`define CW_MUX_HI 14
`define CW_MUX_LO 12
`define CW_GAIN_HI 11
`define CW_GAIN_LO 9
`define CW_MODE 8
`define CW_RATE_HI 7
`define CW_RATE_LO 5
`define CW_TEMP 4
`define CW_PULLUP 3
`define CW_VALID_HI 2
`define CW_VALID_LO 1
`define CW_RSVD 0

`define WRITE_VALID 2'h1
`define WORD_BITS 6'h10
`define FRAME_BITS 6'h20
`define FIFO_WIDTH 16
`define FIFO_DEPTH 8
`define RAW_WIDTH 18

`endif

// ===== adc_spi_result_config_port.v
// Converter serial port: result shift-out, configuration shift-in,
// readback, conversion start control and the result FIFO.
// Assumes the converter core returns raw results on a valid/ready
// stream, and that pins arrive asynchronously to clk_i.
//
// Contract
// R1: Results are 16-bit two's complement, saturating at 7FFFh and 8000h.
// R2: Ideal codes: one LSB gives 0001h, zero gives 0, minus one LSB FFFFh.
// R3: Reads and writes share one serial procedure in both modes.
// R4: Mode bit 0 keeps starting conversions back to back, any select level; starts wait while the result FIFO is full.
//     Code still starts one conversion after the push that fills the FIFO; its result waits in ST_CONV for room.
// R5: Mode bit 1 starts a conversion only on a written start bit.
// R6: Latest result stays buffered until a newer one replaces it.
// R7: Result bit 15 leaves on first rising clock edge, then descending.
// R8: Configuration bits are captured on serial clock falling edges.
// R9: Transfers are 32 bits with readback, or 16 bits with select driven.
// R10: A 32-bit transfer sends two result bytes then two readback bytes.
// R11: Host repeats the word or holds input constant in 32-bit transfers.
// R12: Word received in first half is returned in second half.
// R13: Host raises select after 16th clock; select high resets serial state.
// R14: Select fall starts with the buffered result, fresh or repeated.
// R15: Exactly two registers: read-only result and read/write configuration.
// R16: Result register is 0000h after reset until first conversion.
// R17: Configuration resets to 058Bh with the documented field layout.
// R18: Start bit starts one conversion when idle, else nothing; reads 0; readback_reg returns it as written.
// R19: Input select codes choose the differential or grounded input pair.
// R20: Configuration updates only when the write-valid field equals 01.
// R21: With select low, data line goes low when a new result is ready.
// R22: Mode 1: clock idles low, data change rising, sampled falling.
// R23: A valid word applies once its sixteenth bit is captured.
`timescale 1ns/100ps
`include "adc_spi_map.vh"

module result_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8
) (
	input wire clk_i,
	input wire srst_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [WIDTH-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [WIDTH-1:0] out_data_o
);
	localparam AW = $clog2(DEPTH);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire push;
	wire pop;

	assign in_ready_o = (count_reg != DEPTH[AW:0]);
	assign out_valid_o = (count_reg != {(AW+1){1'b0}});
	assign out_data_o = mem[rd_ptr_reg];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;

	always @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (srst_i) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push & ~pop) begin
				count_reg <= count_reg + 1'b1;
			end else if (pop & ~push) begin
				count_reg <= count_reg - 1'b1;
			end
		end
	end
endmodule // result_fifo

module adc_spi_result_config_port (
	input wire clk_i,
	input wire srst_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire din_i,
	output reg data_out_ready_n_o,
	output reg data_out_oe_o,
	output reg pullup_on_o,
	output reg conv_start_o,
	input wire conv_valid_i,
	output reg conv_ready_o,
	input wire [`RAW_WIDTH-1:0] conv_data_i,
	output reg [2:0] input_pair_select_o,
	output reg [1:0] ain_pos_o,
	output reg ain_neg_gnd_o,
	output reg [1:0] ain_neg_o,
	output reg [2:0] gain_select_o,
	output reg continuous_o,
	output reg [2:0] rate_select_o,
	output reg temp_sensor_select_o,
	output reg output_pullup_enable_o,
	output reg busy_o
);

	localparam ST_IDLE = 2'b01;
	localparam ST_CONV = 2'b10;

	// Clip a wide signed raw value into 16-bit two's complement
	function [15:0] saturate;
		input [`RAW_WIDTH-1:0] raw;
		begin
			if (!raw[`RAW_WIDTH-1] && (raw[`RAW_WIDTH-2:15] != 0)) begin
				saturate = `RESULT_MAX;
			end else if (raw[`RAW_WIDTH-1] &&
				(raw[`RAW_WIDTH-2:15] != {(`RAW_WIDTH-16){1'b1}})) begin
				saturate = `RESULT_MIN;
			end else begin
				saturate = raw[15:0];
			end
		end
	endfunction

	// Input pair decode: {pos[1:0], neg_is_ground, neg[1:0]}
	function [4:0] pair_decode;
		input [2:0] code;
		begin
			case (code)
				3'h0: pair_decode = {2'h0, 1'b0, 2'h1};
				3'h1: pair_decode = {2'h0, 1'b0, 2'h3};
				3'h2: pair_decode = {2'h1, 1'b0, 2'h3};
				3'h3: pair_decode = {2'h2, 1'b0, 2'h3};
				default: pair_decode = {code[1:0], 1'b1, 2'h0};
			endcase
		end
	endfunction

	// Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
	wire [2:0] pins_in;
	reg [2:0] sync1_reg;
	reg [2:0] sync2_reg;
	reg [2:0] sync3_reg;
	reg [2:0] level_reg;
	assign pins_in = {cs_n_i, sclk_i, din_i};

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_sync
			always @(posedge clk_i) begin
				if (srst_i) begin
					sync1_reg[g] <= (g == 2);
					sync2_reg[g] <= (g == 2);
					sync3_reg[g] <= (g == 2);
					level_reg[g] <= (g == 2);
				end else begin
					sync1_reg[g] <= pins_in[g];
					sync2_reg[g] <= sync1_reg[g];
					sync3_reg[g] <= sync2_reg[g];
					if (sync2_reg[g] == sync3_reg[g]) begin
						level_reg[g] <= sync3_reg[g];
					end
				end
			end
		end
	endgenerate

	wire cs_lvl;
	wire din_lvl;
	wire sclk_now;
	wire sclk_rise;
	wire sclk_fall;
	assign cs_lvl = level_reg[2];
	assign din_lvl = level_reg[0];
	assign sclk_now = (sync2_reg[1] == sync3_reg[1]) ? sync3_reg[1] :
		level_reg[1];
	// Clock edges ignored while select is high
	assign sclk_rise = ~cs_lvl & sclk_now & ~level_reg[1]; // R22
	assign sclk_fall = ~cs_lvl & ~sclk_now & level_reg[1]; // R22

	// Two registers only: result and configuration
	reg [15:0] adc_result_reg; // R15
	reg [15:0] control_word_reg; // R15
	reg [15:0] control_word_next;
	reg [15:0] readback_reg;
	reg [15:0] rx_reg;
	reg [15:0] tx_reg;
	reg [5:0] bit_cnt_reg;
	reg new_data_reg;
	reg shifting_reg;
	reg start_req_reg;
	reg [1:0] state_reg;

	wire [15:0] rx_word;
	wire word_done;
	wire word_ok;
	assign rx_word = {rx_reg[14:0], din_lvl};
	assign word_done = sclk_fall & (bit_cnt_reg == `WORD_BITS - 6'h1); // R23
	assign word_ok = (rx_word[`CW_VALID_HI:`CW_VALID_LO] == `WRITE_VALID);

	wire fifo_out_valid;
	wire fifo_out_ready;
	wire fifo_in_ready;
	wire [15:0] fifo_out_data;
	// Hold results back mid-frame so the FIFO absorbs them
	assign fifo_out_ready = ~shifting_reg; // R6

	result_fifo #(
		.WIDTH(`FIFO_WIDTH),
		.DEPTH(`FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.in_valid_i(conv_valid_i),
		.in_ready_o(fifo_in_ready),
		.in_data_i(saturate(conv_data_i)), // R1 R2
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out_data)
	);

	always @* begin
		control_word_next = control_word_reg;
		if (word_done && word_ok) begin // R20
			// Start bit never stored, reserved bit always 1
			control_word_next = {1'b0, rx_word[14:1], 1'b1}; // R17 R18
		end
	end

	wire result_take;
	assign result_take = fifo_out_valid & fifo_out_ready;

	// Serial engine and register file
	always @(posedge clk_i) begin // R3
		if (srst_i) begin
			adc_result_reg <= `RESULT_RESET; // R16
			control_word_reg <= `CONTROL_RESET; // R17
			readback_reg <= `CONTROL_RESET;
			rx_reg <= 16'h0000;
			tx_reg <= 16'h0000;
			bit_cnt_reg <= 6'h00;
			new_data_reg <= 1'b0;
			shifting_reg <= 1'b0;
			start_req_reg <= 1'b0;
			data_out_ready_n_o <= 1'b1;
			data_out_oe_o <= 1'b0;
			pullup_on_o <= 1'b1;
		end else begin
			control_word_reg <= control_word_next;
			start_req_reg <= word_done & word_ok &
				rx_word[`CW_START]; // R18
			if (result_take) begin
				adc_result_reg <= fifo_out_data; // R6
			end
			if (cs_lvl) begin
				// Select high resets the serial state
				bit_cnt_reg <= 6'h00; // R13
				shifting_reg <= 1'b0; // R13
				data_out_oe_o <= 1'b0;
				data_out_ready_n_o <= 1'b1;
				pullup_on_o <= control_word_reg[`CW_PULLUP];
			end else begin
				data_out_oe_o <= 1'b1;
				pullup_on_o <= 1'b0;
				if (sclk_rise) begin
					shifting_reg <= 1'b1;
					if (bit_cnt_reg == 6'h00) begin
						// Lock the buffered result for the frame
						data_out_ready_n_o <= adc_result_reg[15]; // R7 R14
						tx_reg <= {adc_result_reg[14:0], 1'b0}; // R7
					end else if (bit_cnt_reg == `WORD_BITS) begin
						data_out_ready_n_o <= readback_reg[15]; // R10 R12
						tx_reg <= {readback_reg[14:0], 1'b0}; // R10
					end else begin
						data_out_ready_n_o <= tx_reg[15]; // R7
						tx_reg <= {tx_reg[14:0], 1'b0};
					end
				end else if (!shifting_reg) begin
					data_out_ready_n_o <= ~new_data_reg; // R21
				end
				if (sclk_fall) begin
					rx_reg <= rx_word; // R8
					if (bit_cnt_reg == `FRAME_BITS - 6'h1) begin
						// Select tied low: frame ends after 32 clocks
						bit_cnt_reg <= 6'h00; // R9
						shifting_reg <= 1'b0;
					end else begin
						bit_cnt_reg <= bit_cnt_reg + 6'h01;
					end
					if (word_done) begin
						readback_reg <= rx_word; // R12
					end
				end
			end
			// New result wins over the read that clears the flag
			if (result_take) begin
				new_data_reg <= 1'b1; // R21
			end else if (sclk_rise && bit_cnt_reg == 6'h00) begin
				new_data_reg <= 1'b0; // R14
			end
		end
	end

	// Conversion sequencing, same for either mode's data access
	always @(posedge clk_i) begin
		if (srst_i) begin
			state_reg <= ST_IDLE;
			conv_start_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			conv_start_o <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (!control_word_reg[`CW_MODE] || start_req_reg) begin // R4 R5
						conv_start_o <= 1'b1;
						busy_o <= 1'b1;
						state_reg <= ST_CONV;
					end
				end
				ST_CONV: begin
					// Start requests here are dropped
					if (conv_valid_i && fifo_in_ready) begin // R18
						busy_o <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: begin
					state_reg <= ST_IDLE;
					busy_o <= 1'b0;
				end
			endcase
		end
	end

	// Registered field outputs toward the analog front end
	always @(posedge clk_i) begin
		if (srst_i) begin
			conv_ready_o <= 1'b0;
			input_pair_select_o <= 3'h0;
			{ain_pos_o, ain_neg_gnd_o, ain_neg_o} <= 5'h01;
			gain_select_o <= 3'h0;
			continuous_o <= 1'b0;
			rate_select_o <= 3'h0;
			temp_sensor_select_o <= 1'b0;
			output_pullup_enable_o <= 1'b0;
		end else begin
			conv_ready_o <= fifo_in_ready;
			input_pair_select_o <=
				control_word_reg[`CW_MUX_HI:`CW_MUX_LO];
			{ain_pos_o, ain_neg_gnd_o, ain_neg_o} <= pair_decode(
				control_word_reg[`CW_MUX_HI:`CW_MUX_LO]); // R19
			gain_select_o <= control_word_reg[`CW_GAIN_HI:`CW_GAIN_LO];
			continuous_o <= ~control_word_reg[`CW_MODE];
			rate_select_o <= control_word_reg[`CW_RATE_HI:`CW_RATE_LO];
			temp_sensor_select_o <= control_word_reg[`CW_TEMP];
			output_pullup_enable_o <= control_word_reg[`CW_PULLUP];
		end
	end
endmodule // adc_spi_result_config_port

// ===== spi_host_model.sv
// Host side model: a mode 1 master on select, clock and data lines.
// Assumes the bench resolves the shared data line into line_i.
`timescale 1ns/100ps
module spi_host (
	input wire clk_i,
	input wire line_i,
	output reg cs_n_o,
	output reg sclk_o,
	output reg din_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		din_o = 1'b0;
	end
	task xfer(input integer n, input [15:0] w, output rdy,
		output [31:0] r);
		integer i;
		begin
			@(posedge clk_i);
			#1 cs_n_o = 1'b0;
			#160 rdy = line_i;
			r = 32'h0;
			for (i = 0; i < n; i = i + 1) begin
				sclk_o = 1'b1;
				din_o = w[15 - i % 16];
				#80 sclk_o = 1'b0;
				// Late sample leaves room for the pin synchronisers
				#78 r = {r[30:0], line_i};
				#2;
			end
			cs_n_o = 1'b1;
			#320;
		end
	endtask
endmodule // spi_host

// ===== adc_spi_result_config_port_monitor.sv
// Checker for the converter serial port, bound to its top module.
// Assumes pins settle through the synchronisers within eight clocks.
`timescale 1ns/100ps
module port_monitor (
	input wire clk_i,
	input wire srst_i,
	input wire cs_n_i,
	input wire conv_ready_o,
	input wire data_out_oe_o,
	input wire pullup_on_o,
	input wire output_pullup_enable_o,
	input wire conv_start_o,
	input wire busy_o,
	input wire continuous_o,
	input wire [2:0] input_pair_select_o,
	input wire [1:0] ain_pos_o,
	input wire ain_neg_gnd_o,
	input wire [1:0] ain_neg_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_start_busy: assert property (conv_start_o |-> busy_o)
		else $error("start without busy");
	a_no_restart: assert property ($past(busy_o) |-> !conv_start_o)
		else $error("start while busy");
	a_oe_off: assert property (cs_n_i [*8] |=> !data_out_oe_o)
		else $error("line driven while deselected");
	a_oe_on: assert property (!cs_n_i [*8] |=> data_out_oe_o)
		else $error("line not driven while selected");
	a_pullup_cs: assert property (cs_n_i [*8] |=>
		pullup_on_o == output_pullup_enable_o)
		else $error("pullup wrong");
	a_mux_ground: assert property (
		$stable(input_pair_select_o) [*3] ##0 input_pair_select_o[2]
		|-> ain_neg_gnd_o && ain_pos_o == input_pair_select_o[1:0])
		else $error("grounded pair decode wrong");
	a_mux_pair: assert property (
		$stable(input_pair_select_o) [*3] ##0 !input_pair_select_o[2]
		|-> !ain_neg_gnd_o
		&& ain_neg_o == (input_pair_select_o == 3'h0 ? 2'h1 : 2'h3))
		else $error("differential pair decode wrong");
	a_cont_restart: assert property (
		continuous_o && $fell(busy_o) ##1 continuous_o
		|-> ##[0:3] conv_start_o)
		else $error("continuous restart missing");
	c_start: cover property (conv_start_o);
	c_full: cover property (!conv_ready_o);
	c_ground: cover property (ain_neg_gnd_o);
endmodule // port_monitor

bind adc_spi_result_config_port port_monitor u_mon (.clk_i, .srst_i,
	.cs_n_i, .conv_ready_o, .data_out_oe_o, .pullup_on_o,
	.output_pullup_enable_o, .conv_start_o, .busy_o, .continuous_o,
	.input_pair_select_o, .ain_pos_o, .ain_neg_gnd_o, .ain_neg_o);

// ===== adc_spi_result_config_port_bench.sv
// Bench for the converter serial port: host model, core model, checks.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module adc_spi_result_config_port_bench;
	reg clk_i = 1'b0;
	reg srst_i = 1'b1;
	reg conv_valid_i = 1'b0;
	reg [17:0] conv_data_i = 18'h0;
	wire cs_n_i, sclk_i, din_i, data_out_ready_n_o, data_out_oe_o;
	wire pullup_on_o, conv_start_o, conv_ready_o, continuous_o, busy_o;
	wire ain_neg_gnd_o, temp_sensor_select_o, output_pullup_enable_o;
	wire [2:0] input_pair_select_o, gain_select_o, rate_select_o;
	wire [1:0] ain_pos_o, ain_neg_o;
	wire line = data_out_oe_o ? data_out_ready_n_o : pullup_on_o;
	integer errors = 0;
	integer num_checks = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] lfsr = 32'h7A21;
	reg [31:0] r;
	reg rdy;
	reg saw_full = 1'b0;
	reg [15:0] w;
	reg [15:0] cfg = 16'h058B;
	reg [15:0] res = 16'h0000;
	adc_spi_result_config_port u_dut (.clk_i, .srst_i, .cs_n_i, .sclk_i,
		.din_i, .data_out_ready_n_o, .data_out_oe_o, .pullup_on_o,
		.conv_start_o, .conv_valid_i, .conv_ready_o, .conv_data_i,
		.input_pair_select_o, .ain_pos_o, .ain_neg_gnd_o, .ain_neg_o,
		.gain_select_o, .continuous_o, .rate_select_o, .temp_sensor_select_o,
		.output_pullup_enable_o, .busy_o);
	spi_host u_host (.clk_i, .line_i(line), .cs_n_o(cs_n_i),
		.sclk_o(sclk_i), .din_o(din_i));
	initial forever #10 clk_i = ~clk_i;
	// Core answers one cycle after each start, holds until taken
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (conv_start_o)
			conv_valid_i <= #1 1'b1;
		else if (conv_valid_i && conv_ready_o)
			conv_valid_i <= #1 1'b0;
		if (conv_ready_o === 1'b0)
			saw_full <= 1'b1;
		if (cyc == 20000) begin
			errors = errors + 1;
			finish_test;
		end
	end
	function [31:0] nxt(input [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Raw codes around both clip points and the one-LSB codes
	function [17:0] raw_at(input integer k);
		case (k)
			0: raw_at = 18'h1FFFF;
			1: raw_at = 18'h20000;
			2: raw_at = 18'h00001;
			3: raw_at = 18'h3FFFF;
			4: raw_at = 18'h00000;
			5: raw_at = 18'h08000;
			default: raw_at = 18'h37FFF;
		endcase
	endfunction
	function [15:0] sat(input integer v);
		sat = v > 32767 ? 16'h7FFF : v < -32768 ? 16'h8000 : v[15:0];
	endfunction
	task chk(input [32:0] got, input [32:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task frame(input integer n, input [15:0] v);
		begin
			u_host.xfer(n, v, rdy, r);
			if (v[2:1] == 2'b01)
				cfg = {1'b0, v[14:1], 1'b1};
		end
	endtask
	task chk_cfg;
		reg [2:0] p;
		begin
			p = cfg[14:12];
			chk({input_pair_select_o, gain_select_o, ~continuous_o,
				rate_select_o, temp_sensor_select_o,
				output_pullup_enable_o}, cfg[14:3]);
			chk({ain_neg_gnd_o, ain_pos_o, p[2] ? 2'b00 : ain_neg_o},
				{p[2], p[2] ? p[1:0] : p[1] ? p[1:0] - 2'b01 : 2'b00,
				p[2] ? 2'b00 : p == 3'h0 ? 2'b01 : 2'b11});
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d errors %0d", num_checks, errors);
			if (errors == 0 && num_checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		#1 srst_i = 1'b0;
		frame(32, 16'h0000);
		chk({rdy, r}, {1'b1, 32'h0});
		chk_cfg;
		$display("reset test done");
		// Last three words carry refused write codes
		for (i = 0; i < 11; i = i + 1) begin
			lfsr = nxt(lfsr);
			w = {1'b0, i[2:0], lfsr[2:0], 1'b1, lfsr[5:3], lfsr[6], lfsr[8],
				i < 8 ? 2'b01 : i[1:0] ^ 2'b10, lfsr[7]};
			frame(32, w);
			chk(r, {res, w});
			chk_cfg;
		end
		$display("config test done");
		for (i = 0; i < 8; i = i + 1) begin
			lfsr = nxt(lfsr);
			conv_data_i = i == 7 ? lfsr[17:0] : raw_at(i);
			frame(16, cfg | 16'h8000);
			res = sat($signed(conv_data_i));
			frame(16, 16'h0000);
			chk({rdy, r[15:0]}, {1'b0, res});
			frame(16, 16'h0000);
			chk({rdy, r[15:0]}, {1'b1, res});
		end
		$display("single shot test done");
		// Long frame stalls the drain so the buffer must fill
		frame(16, cfg & 16'hFEFF);
		saw_full = 1'b0;
		frame(32, 16'h0000);
		chk({saw_full, r}, {1'b1, res, 16'h0000});
		$display("continuous test done");
		finish_test;
	end
endmodule // adc_spi_result_config_port_bench
